// *** gpio_port_cfg.svh ***
// constants and register reset values for the eight-pin port block
//
// How it works
// RULE1: ordinary pins reset tri-stated: alternate, digital enable, pulls all off.
// RULE2: debug pins reset with alternate function, digital enable and pull-up on.
// RULE3: power-on and reset pin both restore every pin's default setup.
// RULE4: direction 0 samples the pin, direction 1 drives stored data.
// RULE5: address bits 9 to 2 form the per-pin data access mask.
// RULE6: data register answers at all 256 mask locations.
// RULE7: data write changes only bits whose mask bit is one.
// RULE8: data read returns zero for bits whose mask bit is zero.
// RULE9: all pin interrupt causes merge into one interrupt output.
// RULE10: edge interrupts stay latched until software clears them.
// RULE11: level sources must hold their level until recognised.
// RULE12: sense bit 0 selects edge detect, 1 selects level detect.
// RULE13: both-edges bit 1 triggers on rising and falling edges.
// RULE14: event bit 0 means low or falling, 1 means high or rising.
// RULE15: mask bit 0 blocks a pin's interrupt, 1 passes it.
// RULE16: raw status ignores mask; masked status shows only passed conditions.
// RULE17: writing 1 to a clear bit clears that pending interrupt.
// RULE18: software masks a pin before changing its interrupt setup.
// RULE19: alternate-function bit hands the pin to its peripheral.
// RULE20: protected alternate bits change only when unlocked and committed.
// RULE21: read-only identification value, fixed at reset.
// RULE22: software enables the port clock before use.
// RULE23: open-drain input needs alternate and direction clear, drain and enable set.
// RULE24: unmasked read gives written value for outputs, pin level for inputs.
// RULE25: pins without a pad ignore writes and read as zero.
// RULE26: interrupt output is the OR of raw status ANDed with mask.
`ifndef GPIO_PORT_CFG_SVH
`define GPIO_PORT_CFG_SVH

// ----------------------------------------------------------------
// widths and reset values
// ----------------------------------------------------------------
`define GP_PINS          8
`define GP_KEY_W         32
`define GP_ZERO8         8'h00
`define GP_ONES8         8'hFF
`define GP_DRV2_RST      8'hFF
`define GP_LOCKED_RST    1'b1

`endif

// *** gpio_port_pkg.sv ***
// types shared by the port block
package gpio_port_pkg;
    // pad setup bits, one byte per control, bit n belongs to pin n
    typedef struct packed {
        logic [7:0] alt_function_select;
        logic [7:0] digital_pad_enable;
        logic [7:0] pull_up_select;
        logic [7:0] pull_down_select;
        logic [7:0] open_drain_select;
        logic [7:0] drive_low_select;
        logic [7:0] drive_mid_select;
        logic [7:0] drive_high_select;
        logic [7:0] slew_control_select;
    } pad_cfg_t;

    // interrupt setup, level inputs from the control side
    typedef struct packed {
        logic [7:0] irq_sense_select;
        logic [7:0] irq_both_edges;
        logic [7:0] irq_event_polarity;
        logic [7:0] irq_mask;
    } irq_cfg_t;
endpackage

// *** gpio_port_block.sv ***
// eight-pin general-purpose port: masked data access, pin interrupts, pad setup
`timescale 1ns/1ps
`default_nettype none
`include "gpio_port_cfg.svh"

module gpio_port_block #(
    parameter logic [7:0]  PIN_MASK   = 8'hFF,        // pins that have a pad
    parameter logic [7:0]  DEBUG_MASK = 8'h00,        // pins reserved for debug port
    parameter logic [31:0] UNLOCK_KEY = 32'h1234_5678, // arbitrary value
    parameter logic [31:0] ID_CODE    = 32'h0000_0ABC  // arbitrary value
) (
    input  wire logic                  I_CLK_SYS,
    input  wire logic                  I_SYS_RST,
    input  wire logic [7:0]            I_PIN_IN,
    output logic      [7:0]            O_PIN_OUT,
    output logic      [7:0]            O_PIN_OE,
    input  wire logic [7:0]            I_ALT_OUT,
    input  wire logic [7:0]            I_ALT_OE,
    output logic      [7:0]            O_ALT_IN,
    input  wire logic                  I_DATA_WR,
    input  wire logic                  I_DATA_RD,
    input  wire logic [7:0]            I_DATA_ADDR,
    input  wire logic [7:0]            I_DATA_WDATA,
    output logic      [7:0]            O_DATA_RDATA,
    input  wire logic [7:0]            I_DIR,
    input  wire gpio_port_pkg::irq_cfg_t I_IRQ_CFG,
    input  wire logic [7:0]            I_IRQ_CLEAR,
    output logic      [7:0]            O_IRQ_RAW,
    output logic      [7:0]            O_IRQ_MASKED,
    output logic                       O_IRQ,
    input  wire logic                  I_PAD_WR,
    input  wire gpio_port_pkg::pad_cfg_t I_PAD_WDATA,
    output gpio_port_pkg::pad_cfg_t    O_PAD_CFG,
    input  wire logic                  I_LOCK_WR,
    input  wire logic [31:0]           I_LOCK_WDATA,
    output logic                       O_LOCKED,
    input  wire logic                  I_COMMIT_WR,
    input  wire logic [7:0]            I_COMMIT_WDATA,
    output logic      [7:0]            O_COMMIT,
    output logic      [31:0]           O_ID
);
    import gpio_port_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [7:0] pin_meta_r;
    logic [7:0] pin_sync_r;
    logic [7:0] pin_prev_r;
    logic [7:0] data_r;
    logic [7:0] raw_r;
    logic [7:0] commit_r;
    logic       locked_r;
    pad_cfg_t   pad_r;
    pad_cfg_t   pad_nxt;
    pad_cfg_t   pad_rst;
    logic [7:0] data_nxt;
    logic [7:0] raw_nxt;
    logic [7:0] commit_nxt;
    logic [7:0] masked_nxt;

    // ----------------------------------------------------------------
    // pin input synchroniser
    // ----------------------------------------------------------------
    // pins are asynchronous; only pin_sync_r and pin_prev_r feed logic
    always_ff @(posedge I_CLK_SYS) begin
        if (I_SYS_RST) begin
            pin_meta_r <= `GP_ZERO8;
            pin_sync_r <= `GP_ZERO8;
            pin_prev_r <= `GP_ZERO8;
        end else begin
            pin_meta_r <= I_PIN_IN;
            pin_sync_r <= pin_meta_r;
            pin_prev_r <= pin_sync_r;
        end
    end

    // ----------------------------------------------------------------
    // data register decode
    // ----------------------------------------------------------------
    wire [7:0] wr_bits  = I_DATA_ADDR & PIN_MASK;          // [RULE5] [RULE25]
    // every mask value is a valid location, no address is unmapped
    wire [7:0] pin_view = (I_DIR & data_r) | (~I_DIR & pin_sync_r); // [RULE4] [RULE24]
    wire [7:0] rd_value = pin_view & I_DATA_ADDR & PIN_MASK; // [RULE6] [RULE8]

    assign data_nxt = I_DATA_WR ? ((data_r & ~wr_bits) | (I_DATA_WDATA & wr_bits))
                                : data_r;                   // [RULE7]

    // ----------------------------------------------------------------
    // interrupt detection
    // ----------------------------------------------------------------
    wire [7:0] sense   = I_IRQ_CFG.irq_sense_select;
    wire [7:0] both    = I_IRQ_CFG.irq_both_edges;
    wire [7:0] polar   = I_IRQ_CFG.irq_event_polarity;
    wire [7:0] rise    = pin_sync_r & ~pin_prev_r;
    wire [7:0] fall    = ~pin_sync_r & pin_prev_r;
    wire [7:0] edge_hit = (both & (rise | fall))
                        | (~both & polar & rise)
                        | (~both & ~polar & fall);          // [RULE13] [RULE14]
    wire [7:0] level_hit = (polar & pin_sync_r) | (~polar & ~pin_sync_r); // [RULE14]

    // edge bits latch, set beats clear; level bits follow the pin
    assign raw_nxt = ((sense & level_hit)
                   | (~sense & ((raw_r & ~I_IRQ_CLEAR) | edge_hit)))
                   & PIN_MASK;                              // [RULE10] [RULE12] [RULE17]
    assign masked_nxt = raw_nxt & I_IRQ_CFG.irq_mask;      // [RULE15] [RULE16]

    // ----------------------------------------------------------------
    // lock and commit
    // ----------------------------------------------------------------
    // commit bits of unprotected pins stay 1, so only debug pins are guarded
    assign commit_nxt = (I_COMMIT_WR && !locked_r)
                      ? ((I_COMMIT_WDATA & DEBUG_MASK) | ~DEBUG_MASK)
                      : commit_r;
    wire [7:0] afsel_ok = locked_r ? ~DEBUG_MASK : (commit_r | ~DEBUG_MASK); // [RULE20]

    // pad write; protected alternate bits keep their value unless allowed
    always_comb begin
        pad_nxt = pad_r;
        if (I_PAD_WR) begin
            pad_nxt = I_PAD_WDATA & {9{PIN_MASK}};           // [RULE25]
            pad_nxt.alt_function_select =
                (pad_r.alt_function_select & ~afsel_ok)
                | (I_PAD_WDATA.alt_function_select & afsel_ok & PIN_MASK); // [RULE20]
        end
    end

    // debug pins come up serving the debug port, the rest undriven
    always_comb begin
        pad_rst                     = '0;                    // [RULE1]
        pad_rst.alt_function_select = DEBUG_MASK;            // [RULE2]
        pad_rst.digital_pad_enable  = DEBUG_MASK;            // [RULE2]
        pad_rst.pull_up_select      = DEBUG_MASK;            // [RULE2]
        pad_rst.drive_low_select    = `GP_DRV2_RST & PIN_MASK;
    end

    // ----------------------------------------------------------------
    // control registers
    // ----------------------------------------------------------------
    // one reset input serves both power-on and the reset pin
    always_ff @(posedge I_CLK_SYS) begin
        if (I_SYS_RST) begin
            pad_r    <= pad_rst;                             // [RULE3]
            data_r   <= `GP_ZERO8;
            raw_r    <= `GP_ZERO8;
            commit_r <= ~DEBUG_MASK;
            locked_r <= `GP_LOCKED_RST;
        end else begin
            pad_r    <= pad_nxt;
            data_r   <= data_nxt;
            raw_r    <= raw_nxt;
            commit_r <= commit_nxt;
            if (I_LOCK_WR) begin
                locked_r <= (I_LOCK_WDATA != UNLOCK_KEY);
            end
        end
    end

    // ----------------------------------------------------------------
    // pin drive
    // ----------------------------------------------------------------
    wire [7:0] afsel   = pad_r.alt_function_select;
    wire [7:0] den     = pad_r.digital_pad_enable;
    wire [7:0] odr     = pad_r.open_drain_select;
    wire [7:0] drv_val = (afsel & I_ALT_OUT) | (~afsel & data_r);  // [RULE19]
    wire [7:0] drv_en  = (afsel & I_ALT_OE) | (~afsel & I_DIR);    // [RULE4] [RULE19]
    // open drain only ever pulls low; a one releases the pad
    wire [7:0] oe_nxt  = den & PIN_MASK & drv_en & ~(odr & drv_val);
    wire [7:0] out_nxt = drv_val & ~odr;

    // ----------------------------------------------------------------
    // output registers
    // ----------------------------------------------------------------
    always_ff @(posedge I_CLK_SYS) begin
        if (I_SYS_RST) begin
            O_PIN_OUT    <= `GP_ZERO8;
            O_PIN_OE     <= `GP_ZERO8;
            O_ALT_IN     <= `GP_ZERO8;
            O_DATA_RDATA <= `GP_ZERO8;
            O_IRQ_RAW    <= `GP_ZERO8;
            O_IRQ_MASKED <= `GP_ZERO8;
            O_IRQ        <= 1'b0;
            O_PAD_CFG    <= pad_rst;
            O_LOCKED     <= `GP_LOCKED_RST;
            O_COMMIT     <= ~DEBUG_MASK;
            O_ID         <= ID_CODE;                         // [RULE21]
        end else begin
            O_PIN_OUT    <= out_nxt;
            O_PIN_OE     <= oe_nxt;
            O_ALT_IN     <= pin_sync_r & den;
            O_DATA_RDATA <= I_DATA_RD ? rd_value : `GP_ZERO8;
            O_IRQ_RAW    <= raw_nxt;                         // [RULE16]
            O_IRQ_MASKED <= masked_nxt;
            O_IRQ        <= |masked_nxt;                     // [RULE9] [RULE26]
            O_PAD_CFG    <= pad_nxt;
            O_LOCKED     <= I_LOCK_WR ? (I_LOCK_WDATA != UNLOCK_KEY) : locked_r;
            O_COMMIT     <= commit_nxt;
            O_ID         <= ID_CODE;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    // ordinary pins undriven and unpulled after any reset
    a_reset_defaults: assert property (@(posedge I_CLK_SYS) // [RULE1]
        I_SYS_RST |=> (pad_r.alt_function_select == DEBUG_MASK
            && pad_r.pull_down_select == 8'h00 && O_PIN_OE == 8'h00))
        else $error("pad setup wrong after reset");

    // debug pins return to the debug port
    a_debug_pullup: assert property (@(posedge I_CLK_SYS) // [RULE2]
        I_SYS_RST |=> (pad_r.pull_up_select == DEBUG_MASK
            && pad_r.digital_pad_enable == DEBUG_MASK))
        else $error("debug pins not restored by reset");

    // any reset also relocks and clears the data
    a_reset_relock: assert property (@(posedge I_CLK_SYS) // [RULE3]
        I_SYS_RST |=> (locked_r && commit_r == ~DEBUG_MASK && data_r == 8'h00))
        else $error("lock or data not restored by reset");

    // only addressed bits take the write
    a_data_write_mask: assert property (@(posedge I_CLK_SYS) disable iff (I_SYS_RST) // [RULE7]
        I_DATA_WR |=> ((data_r & $past(wr_bits)) == ($past(I_DATA_WDATA) & $past(wr_bits))
            && (data_r & ~$past(wr_bits)) == ($past(data_r) & ~$past(wr_bits))))
        else $error("masked data write wrong");

    // unaddressed bits read as zero
    a_data_read_mask: assert property (@(posedge I_CLK_SYS) disable iff (I_SYS_RST) // [RULE8]
        I_DATA_RD |=> (O_DATA_RDATA & ~$past(I_DATA_ADDR)) == 8'h00)
        else $error("masked-off read bit not zero");

    // full-mask read shows stored data or pin level
    a_read_source: assert property (@(posedge I_CLK_SYS) disable iff (I_SYS_RST) // [RULE24]
        (I_DATA_RD && I_DATA_ADDR == 8'hFF) |=>
            O_DATA_RDATA == ($past(pin_view) & PIN_MASK))
        else $error("read source wrong");

    // no mask value is unmapped
    a_any_address: assert property (@(posedge I_CLK_SYS) disable iff (I_SYS_RST) // [RULE6]
        I_DATA_RD |=> O_DATA_RDATA == ($past(pin_view & I_DATA_ADDR) & PIN_MASK))
        else $error("read at some mask address lost");

    // latched edge survives until a clear
    a_edge_latched: assert property (@(posedge I_CLK_SYS) disable iff (I_SYS_RST) // [RULE10]
        ##1 (($past(raw_r & ~sense & ~I_IRQ_CLEAR) & ~raw_r) == 8'h00))
        else $error("edge interrupt lost without clear");

    // a clear with no new edge empties the bit
    a_clear_works: assert property (@(posedge I_CLK_SYS) disable iff (I_SYS_RST) // [RULE17]
        ##1 ((raw_r & $past(I_IRQ_CLEAR & ~sense & ~edge_hit)) == 8'h00))
        else $error("interrupt clear ignored");

    // both-edges pins set on any change
    a_edge_set: assert property (@(posedge I_CLK_SYS) disable iff (I_SYS_RST) // [RULE13]
        ##1 (($past(~sense & both & (pin_sync_r ^ pin_prev_r) & PIN_MASK) & ~raw_r) == 8'h00))
        else $error("both-edge change not latched");

    // level pins set while the level matches
    a_level_follow: assert property (@(posedge I_CLK_SYS) disable iff (I_SYS_RST) // [RULE12]
        ##1 ((~raw_r & $past(sense & PIN_MASK & ~(polar ^ pin_sync_r))) == 8'h00))
        else $error("level interrupt not raised");

    // level pins drop when the level disagrees
    a_level_polarity: assert property (@(posedge I_CLK_SYS) disable iff (I_SYS_RST) // [RULE14]
        ##1 ((raw_r & $past(sense & (polar ^ pin_sync_r))) == 8'h00))
        else $error("level interrupt of wrong polarity");

    // masked status is raw status gated by the mask
    a_masked_status: assert property (@(posedge I_CLK_SYS) disable iff (I_SYS_RST) // [RULE15]
        ##1 (O_IRQ_MASKED == (O_IRQ_RAW & $past(I_IRQ_CFG.irq_mask))))
        else $error("masked status not raw and mask");

    // interrupt output is the OR of masked raw bits
    a_irq_or: assert property (@(posedge I_CLK_SYS) disable iff (I_SYS_RST) // [RULE26]
        ##1 (O_IRQ == |(O_IRQ_RAW & $past(I_IRQ_CFG.irq_mask))))
        else $error("interrupt output not OR of masked raw");

    // one output for all pins
    a_irq_single: assert property (@(posedge I_CLK_SYS) disable iff (I_SYS_RST) // [RULE9]
        ##1 (O_IRQ == (O_IRQ_MASKED != 8'h00)))
        else $error("interrupt output disagrees with status");

    // protected alternate bits frozen while locked
    a_afsel_guard: assert property (@(posedge I_CLK_SYS) disable iff (I_SYS_RST) // [RULE20]
        (I_PAD_WR && locked_r) |=>
            (pad_r.alt_function_select & DEBUG_MASK)
                == ($past(pad_r.alt_function_select) & DEBUG_MASK))
        else $error("protected alternate bit changed while locked");

    // commit bits frozen while locked
    a_commit_locked: assert property (@(posedge I_CLK_SYS) disable iff (I_SYS_RST) // [RULE20]
        (I_COMMIT_WR && locked_r) |=> commit_r == $past(commit_r))
        else $error("commit bits changed while locked");

    // alternate pins take their enable from the peripheral
    a_alt_drive: assert property (@(posedge I_CLK_SYS) disable iff (I_SYS_RST) // [RULE19]
        ##1 (((O_PIN_OE ^ $past(I_ALT_OE)) & $past(afsel & den & ~odr & PIN_MASK)) == 8'h00))
        else $error("peripheral does not own pin");

    // port pins take their enable from the direction
    a_gpio_drive: assert property (@(posedge I_CLK_SYS) disable iff (I_SYS_RST) // [RULE4]
        ##1 (((O_PIN_OE ^ $past(I_DIR)) & $past(~afsel & den & ~odr & PIN_MASK)) == 8'h00))
        else $error("pin enable does not follow direction");

    // port pins drive the stored data bit
    a_data_out: assert property (@(posedge I_CLK_SYS) disable iff (I_SYS_RST) // [RULE4]
        ##1 (((O_PIN_OUT ^ $past(data_r)) & $past(~afsel & ~odr)) == 8'h00))
        else $error("pin value not the stored data");

    // pins without a pad stay silent
    a_nopad_quiet: assert property (@(posedge I_CLK_SYS) disable iff (I_SYS_RST) // [RULE25]
        ##1 (((O_PIN_OE | O_DATA_RDATA | raw_r | data_r) & ~PIN_MASK) == 8'h00))
        else $error("unconnected pin bit active");

    // identification never moves
    a_id_fixed: assert property (@(posedge I_CLK_SYS) disable iff (I_SYS_RST) // [RULE21]
        ##1 (O_ID == ID_CODE))
        else $error("identification value changed");
endmodule
`default_nettype wire

// *** pin_partner.sv ***
// pad-side partner: resolves each pin from the port, an outside driver and the pulls
`timescale 1ns/1ps
`default_nettype none
module pin_partner (
    input  wire logic                    i_clk,
    input  wire logic [7:0]              i_pin_out,
    input  wire logic [7:0]              i_pin_oe,
    input  wire gpio_port_pkg::pad_cfg_t i_cfg,
    input  wire logic [7:0]              i_ext_val,
    input  wire logic [7:0]              i_ext_oe,
    output logic      [7:0]              o_pin_lvl
);
    import gpio_port_pkg::*;
    logic [7:0] last_r = 8'h00;
    // ----------------------------------------------------------------
    // pad resolution
    // ----------------------------------------------------------------
    // outside driver holds its level as long as told, steady for level detect
    // a floating pad shows the inverse of its last level, never a stale value
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (i_pin_oe[i]) begin
                o_pin_lvl[i] = i_pin_out[i];
            end else if (i_ext_oe[i]) begin
                o_pin_lvl[i] = i_ext_val[i];
            end else if (i_cfg.pull_up_select[i]) begin
                o_pin_lvl[i] = 1'b1;
            end else if (i_cfg.pull_down_select[i]) begin
                o_pin_lvl[i] = 1'b0;
            end else begin
                o_pin_lvl[i] = ~last_r[i];
            end
        end
    end
    // remembers the level so an undriven pad keeps moving
    always_ff @(posedge i_clk) begin
        last_r <= o_pin_lvl;
    end
endmodule
`default_nettype wire

// *** gpio_port_block_tb.sv ***
// self-checking bench for the eight-pin port block
`timescale 1ns/1ps
`default_nettype none
module gpio_port_block_tb;
    import gpio_port_pkg::*;
    localparam logic [31:0] KEY = 32'h1357_2468; // arbitrary value
    localparam logic [31:0] IDC = 32'h0000_0C0D; // arbitrary value
    localparam logic [71:0] PAD_RST = 72'h80_80_80_00_00_FF_00_00_00;
    logic       clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
    logic       pad_wr = 1'b0, lock_wr = 1'b0, cm_wr = 1'b0, irq, locked;
    logic [7:0] addr = 8'h00, wdata = 8'h00, dir = 8'h00, irq_clr = 8'h00;
    logic [7:0] alt_out = 8'h00, alt_oe = 8'h00, ext = 8'h00, ext_oe = 8'h00;
    logic [7:0] cm_wd = 8'h00, pin_in, pin_out, pin_oe, alt_in, rdata, raw, msk, cm;
    logic [7:0] e = 8'h00, w, a8;
    logic [31:0] lock_wd = 32'h0, id;
    irq_cfg_t   irq_cfg = irq_cfg_t'(32'h0);
    pad_cfg_t   pad_wd = pad_cfg_t'(72'h0), pad;
    int         mismatches = 0, total_checks = 0;
    // ----------------------------------------------------------------
    // clock, dut, pad partner
    // ----------------------------------------------------------------
    // port clock runs from time zero, ahead of any access
    initial begin
        forever #12.5 clk = ~clk;
    end
    gpio_port_block #(.DEBUG_MASK(8'h80), .UNLOCK_KEY(KEY), .ID_CODE(IDC)) u_dut (
        .I_CLK_SYS(clk), .I_SYS_RST(rst), .I_PIN_IN(pin_in), .O_PIN_OUT(pin_out),
        .O_PIN_OE(pin_oe), .I_ALT_OUT(alt_out), .I_ALT_OE(alt_oe), .O_ALT_IN(alt_in),
        .I_DATA_WR(wr), .I_DATA_RD(rd), .I_DATA_ADDR(addr), .I_DATA_WDATA(wdata),
        .O_DATA_RDATA(rdata), .I_DIR(dir), .I_IRQ_CFG(irq_cfg), .I_IRQ_CLEAR(irq_clr),
        .O_IRQ_RAW(raw), .O_IRQ_MASKED(msk), .O_IRQ(irq), .I_PAD_WR(pad_wr),
        .I_PAD_WDATA(pad_wd), .O_PAD_CFG(pad), .I_LOCK_WR(lock_wr),
        .I_LOCK_WDATA(lock_wd), .O_LOCKED(locked), .I_COMMIT_WR(cm_wr),
        .I_COMMIT_WDATA(cm_wd), .O_COMMIT(cm), .O_ID(id));
    pin_partner u_pins (.i_clk(clk), .i_pin_out(pin_out), .i_pin_oe(pin_oe),
        .i_cfg(pad), .i_ext_val(ext), .i_ext_oe(ext_oe), .o_pin_lvl(pin_in));
    // ----------------------------------------------------------------
    // access tasks, all driven at the falling edge
    // ----------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic chk(input logic [71:0] seen, input logic [71:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // idle cycle after each strobe so it never rises in the step it fell
    task automatic dwr(input logic [7:0] a, input logic [7:0] d);
        wr = 1'b1;
        addr = a;
        wdata = d;
        tick(1);
        wr = 1'b0;
        tick(1);
    endtask
    // read data is registered on the taking edge and checked half a cycle later
    task automatic drd(input logic [7:0] a, input logic [7:0] x);
        rd = 1'b1;
        addr = a;
        tick(1);
        chk(72'(rdata), 72'(x));
        rd = 1'b0;
        tick(1);
    endtask
    // k: 0 pad setup, 1 lock key, 2 commit bits
    task automatic wcfg(input int k);
        pad_wr = (k == 0);
        lock_wr = (k == 1);
        cm_wr = (k == 2);
        tick(1);
        pad_wr = 1'b0;
        lock_wr = 1'b0;
        cm_wr = 1'b0;
        tick(2);
    endtask
    task automatic clr(input logic [7:0] v);
        irq_clr = v;
        tick(1);
        irq_clr = 8'h00;
        tick(2);
    endtask
    // pin change reaches the status three rising edges later, six leaves margin
    task automatic pin_to(input logic [7:0] v, input logic [7:0] r);
        ext = v;
        tick(6);
        chk(72'(raw), 72'(r));
        chk(72'(msk), 72'(r & 8'h05));
        chk(72'(irq), 72'(|(r & 8'h05)));
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // hang guard
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        end_of_test;
    end
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        tick(5);
        rst = 1'b0;
        tick(1);
        chk(pad, PAD_RST);
        chk(72'(locked), 72'h1);
        chk(72'(cm), 72'h7F);
        chk(72'(id), 72'(IDC));
        chk(72'(pin_oe), 72'h00);
        // debug pin is the peripheral's until released
        alt_oe = 8'h80;
        alt_out = 8'h80;
        tick(6);
        chk(72'(pin_oe), 72'h80);
        chk(72'(pin_out), 72'h80);
        chk(72'(alt_in), 72'h80);
        pad_wd = pad_cfg_t'(72'h00_FF_00_00_00_FF_00_00_00);
        wcfg(0);
        chk(pad, 72'h80_FF_00_00_00_FF_00_00_00);
        lock_wd = KEY;
        wcfg(1);
        chk(72'(locked), 72'h0);
        cm_wd = 8'hFF;
        wcfg(2);
        wcfg(0);
        chk(pad, 72'(pad_wd));
        lock_wd = 32'h0;
        wcfg(1);
        cm_wd = 8'h00;
        wcfg(2);
        chk(72'(cm), 72'hFF);
        alt_oe = 8'h00;
        // every mask address, all pins outputs
        dir = 8'hFF;
        for (int a = 0; a < 256; a++) begin
            a8 = 8'(a);
            w = 8'hA5 ^ a8;
            e = (e & ~a8) | (w & a8);
            dwr(a8, w);
            drd(a8, e & a8);
        end
        chk(72'(pin_out), 72'(e));
        // upper nibble becomes inputs driven from outside
        dir = 8'h0F;
        ext_oe = 8'hF0;
        ext = 8'hA0;
        tick(4);
        drd(8'hFF, {4'hA, e[3:0]});
        drd(8'h31, {4'hA, e[3:0]} & 8'h31);
        // interrupts: pin0 rising, pin1 both, pin2 high level, pin3 falling
        dir = 8'h00;
        ext_oe = 8'hFF;
        ext = 8'h00;
        irq_cfg = irq_cfg_t'({8'h04, 8'h02, 8'h05, 8'h00});
        tick(6);
        clr(8'hFF);
        irq_cfg.irq_mask = 8'h05; // mask opened only after setup
        pin_to(8'h09, 8'h01);
        pin_to(8'h00, 8'h09);
        clr(8'h01);
        chk(72'(raw), 72'h08);
        pin_to(8'h02, 8'h0A);
        clr(8'h02);
        pin_to(8'h00, 8'h0A);
        clr(8'hFF);
        pin_to(8'h04, 8'h04);
        clr(8'h04);
        chk(72'(raw), 72'h04);
        pin_to(8'h00, 8'h00);
        // open-drain input: alternate and direction clear, drain and enable set
        ext = 8'h3C;
        pad_wd = pad_cfg_t'(72'h00_FF_00_00_FF_FF_00_00_00);
        wcfg(0);
        chk(pad, 72'(pad_wd));
        drd(8'hFF, 8'h3C);
        chk(72'(pin_oe), 72'h00);
        // open-drain output only ever pulls low
        dir = 8'hFF;
        tick(2);
        chk(72'(pin_oe), 72'({~e}));
        chk(72'(pin_out), 72'h00);
        // second reset in mid-run
        rst = 1'b1;
        tick(5);
        rst = 1'b0;
        tick(1);
        chk(pad, PAD_RST);
        chk(72'(cm), 72'h7F);
        chk(72'(pin_oe), 72'h00);
        end_of_test;
    end
endmodule
`default_nettype wire
